// ==== tuner_cfg_regs.svh ====
// Purpose: Register indices, field positions, masks and reset values of the tuner configuration bank
// Assumes: Index values are the destination addresses carried on the control bus
// Notes: Definitions only; included by bare name
`ifndef TUNER_CFG_REGS_SVH
`define TUNER_CFG_REGS_SVH

// ==================================================================
// Register indices (destination addresses)
`define IDX_DECIM_CFG 4'h5
`define IDX_CHIP_CFG 4'h6
`define IDX_PHASE_OFS 4'h7

// ==================================================================
// Writable field masks; reserved bits are dropped on write
`define DECIM_CFG_MASK 32'h007FFFFF
`define CHIP_CFG_BITS 15
`define PHASE_OFS_BITS 8

// ==================================================================
// Reset values
`define DECIM_CFG_RST 23'h000000
`define CHIP_CFG_RST 15'h0000
`define PHASE_OFS_RST 8'h00

// ==================================================================
// Field positions and widths
`define CC_CLEAR_BIT 14
`define PHASE_FRAC_BITS 24
`define SPH_BASE_BIT 24
`define LEVEL_BITS 10

`endif

// ==== tuner_cfg_pkg.sv ====
// Purpose: Types shared by the tuner configuration bank
// Assumes: Field order matches the chip configuration word, bit 14 first
// Notes: Constants live in tuner_cfg_regs.svh
package tuner_cfg_pkg;

	// ==================================================================
	// Chip configuration word, bit 14 down to bit 0
	typedef struct packed {
		logic clear_acc;      // Bit 14
		logic sph_continuous; // Bit 13
		logic [1:0] sph_select; // Bits 12-11
		logic rsmp_load;      // Bit 10
		logic car_load;       // Bit 9
		logic rsmp_ofs_en;    // Bit 8
		logic car_ofs_en;     // Bit 7
		logic [1:0] rsmp_width; // Bits 6-5
		logic [1:0] car_width;  // Bits 4-3
		logic agc_err_sense;  // Bit 2
		logic agc_disable;    // Bit 1
		logic level_sense;    // Bit 0
	} chip_cfg_t;

	// ==================================================================
	// Hold-at-zero lines to each accumulator group
	typedef struct packed {
		logic carrier_nco;
		logic cic_integ;
		logic agc_loop;
		logic ser_shift_cnt;
		logic ser_clk;
		logic rsmp_divider;
	} clear_lines_t;

endpackage

// ==== offset_word_gate.sv ====
// Purpose: Trims an offset frequency word to its programmed width and gates it off
// Assumes: Narrow words sit in the upper bits; lower bits are forced to zero
// Notes: One register stage; instantiated once per oscillator
module offset_word_gate (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [1:0] width_sel,
	input wire logic enable,
	input wire logic [31:0] word_in,
	output logic [31:0] word_out
);
	logic [31:0] mask;

	// ==================================================================
	// Width mask: 00=8, 01=16, 10=24, 11=32 bits kept from the top
	always_comb begin
		unique case (width_sel)
			2'h0: mask = 32'hFF000000;
			2'h1: mask = 32'hFFFF0000;
			2'h2: mask = 32'hFFFFFF00;
			2'h3: mask = 32'hFFFFFFFF;
		endcase
	end

	// Disabled offset is a hard zero, not a stale word
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			word_out <= 32'h00000000;
		end else begin
			word_out <= enable ? (word_in & mask) : 32'h00000000;
		end
	end

	property p_off_is_zero;
		@(posedge clk) disable iff (!nrst) !enable |=> word_out == 32'h00000000;
	endproperty
	a_off_is_zero: assert property (p_off_is_zero) else $error("disabled offset not zero");

	property p_width8;
		@(posedge clk) disable iff (!nrst)
			(enable && width_sel == 2'h0) |=> word_out[23:0] == 24'h000000;
	endproperty
	a_width8: assert property (p_width8) else $error("8-bit offset leaks low bits");
endmodule

// ==== tuner_cfg_bank.sv ====
// Purpose: Chip configuration, phase offset and decimating filter registers of the tuner
// Assumes: Host writes whole words on cfg_we; all inputs are on clk
// Notes: Every output is a flop; settings act one edge after the write lands
`include "tuner_cfg_regs.svh"

module tuner_cfg_bank
	import tuner_cfg_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic cfg_we,
	input wire logic [3:0] cfg_addr,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	input wire logic [9:0] level_in,
	input wire logic [9:0] level_threshold,
	output logic level_compare_out,
	input wire logic [9:0] agc_mag_in,
	input wire logic [9:0] agc_threshold,
	output logic signed [1:0] agc_error,
	output logic agc_bypass,
	input wire logic [31:0] car_ofs_in,
	output logic [31:0] car_ofs_out,
	input wire logic [31:0] rsmp_ofs_in,
	output logic [31:0] rsmp_ofs_out,
	output logic car_feedback_en,
	output logic rsmp_feedback_en,
	input wire logic [31:0] rsmp_phase_acc,
	input wire logic output_data_valid,
	input wire logic sample_strobe_in,
	output logic [4:0] sample_phase_out,
	output logic sample_strobe,
	output clear_lines_t clear_lines,
	output logic [31:0] phase_offset_word,
	output logic [22:0] decim_cfg
);
	// ==================================================================
	// Register storage
	chip_cfg_t chip_cfg_r; // Chip configuration
	logic [7:0] phase_ofs_r; // Two's complement phase step
	logic [22:0] decim_cfg_r; // Filter settings, passed through
	logic [4:0] sph_window; // Selected phase window
	logic wr_decim;
	logic wr_chip;
	logic wr_phase;

	assign wr_decim = cfg_we && cfg_addr == `IDX_DECIM_CFG;
	assign wr_chip = cfg_we && cfg_addr == `IDX_CHIP_CFG;
	assign wr_phase = cfg_we && cfg_addr == `IDX_PHASE_OFS;

	// ==================================================================
	// Register writes; reserved bits never reach storage
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			chip_cfg_r <= chip_cfg_t'(`CHIP_CFG_RST);
		end else if (wr_chip) begin
			chip_cfg_r <= chip_cfg_t'(cfg_wdata[`CHIP_CFG_BITS-1:0]);
		end
	end

	// Phase offset keeps only the low byte
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			phase_ofs_r <= `PHASE_OFS_RST;
		end else if (wr_phase) begin
			phase_ofs_r <= cfg_wdata[`PHASE_OFS_BITS-1:0];
		end
	end

	// Filter word is stored for its owner block
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			decim_cfg_r <= `DECIM_CFG_RST;
		end else if (wr_decim) begin
			decim_cfg_r <= 23'(cfg_wdata & `DECIM_CFG_MASK);
		end
	end

	// ==================================================================
	// Read back, one cycle after the address; unmapped reads zero
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cfg_rdata <= 32'h00000000;
		end else begin
			unique case (cfg_addr)
				`IDX_DECIM_CFG: cfg_rdata <= {9'h000, decim_cfg_r};
				`IDX_CHIP_CFG: cfg_rdata <= {17'h00000, chip_cfg_r};
				`IDX_PHASE_OFS: cfg_rdata <= {24'h000000, phase_ofs_r};
				default: cfg_rdata <= 32'h00000000;
			endcase
		end
	end

	// ==================================================================
	// Input level detector with selectable sense
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			level_compare_out <= 1'b0;
		end else if (chip_cfg_r.level_sense) begin
			level_compare_out <= level_in > level_threshold;
		end else begin
			level_compare_out <= level_in <= level_threshold;
		end
	end

	// Gain loop error sign; +1 is 2'sb01, -1 is 2'sb11
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			agc_error <= 2'sh1;
		end else if ((agc_mag_in > agc_threshold) == chip_cfg_r.agc_err_sense) begin
			agc_error <= 2'sh1;
		end else begin
			agc_error <= -2'sh1;
		end
	end

	// Bypass tells the gain stage to hold unity (0 dB)
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			agc_bypass <= 1'b0;
		end else begin
			agc_bypass <= chip_cfg_r.agc_disable;
		end
	end

	// ==================================================================
	// Offset word trimming, one instance per oscillator
	offset_word_gate u_car_gate (
		.clk(clk),
		.nrst(nrst),
		.width_sel(chip_cfg_r.car_width),
		.enable(chip_cfg_r.car_ofs_en),
		.word_in(car_ofs_in),
		.word_out(car_ofs_out)
	);

	offset_word_gate u_rsmp_gate (
		.clk(clk),
		.nrst(nrst),
		.width_sel(chip_cfg_r.rsmp_width),
		.enable(chip_cfg_r.rsmp_ofs_en),
		.word_in(rsmp_ofs_in),
		.word_out(rsmp_ofs_out)
	);

	// Accumulator feedback enables; zero means the accumulator only loads
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			car_feedback_en <= 1'b0;
			rsmp_feedback_en <= 1'b0;
		end else begin
			car_feedback_en <= chip_cfg_r.car_load;
			rsmp_feedback_en <= chip_cfg_r.rsmp_load;
		end
	end

	// ==================================================================
	// Sample phase window: code slides the five-bit slice up by one
	always_comb begin
		unique case (chip_cfg_r.sph_select)
			2'h0: sph_window = rsmp_phase_acc[28:24];
			2'h1: sph_window = rsmp_phase_acc[29:25];
			2'h2: sph_window = rsmp_phase_acc[30:26];
			2'h3: sph_window = rsmp_phase_acc[31:27];
		endcase
	end

	// Gated mode holds the pins between valid samples
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sample_phase_out <= 5'h00;
			sample_strobe <= 1'b0;
		end else if (chip_cfg_r.sph_continuous || output_data_valid) begin
			sample_phase_out <= sph_window;
			sample_strobe <= sample_strobe_in;
		end
	end

	// ==================================================================
	// Clear is a level: held as long as the bit stays 1
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			clear_lines <= '0;
		end else begin
			clear_lines <= {6{chip_cfg_r.clear_acc}};
		end
	end

	// Phase step: 2^32 is a full turn, so n/128 of pi is n << 24
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			phase_offset_word <= 32'h00000000;
		end else begin
			phase_offset_word <= {phase_ofs_r, 24'h000000};
		end
	end

	// Filter settings leave through a flop like every other output
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			decim_cfg <= `DECIM_CFG_RST;
		end else begin
			decim_cfg <= decim_cfg_r;
		end
	end

	// ==================================================================
	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	property p_level_sense;
		chip_cfg_r.level_sense |=> level_compare_out == ($past(level_in) > $past(level_threshold));
	endproperty
	a_level_sense: assert property (p_level_sense) else $error("level compare wrong");

	property p_bypass;
		(wr_chip && cfg_wdata[1]) ##1 1'b1 |=> agc_bypass;
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass not asserted");

	property p_agc_err;
		(!chip_cfg_r.agc_err_sense && agc_mag_in > agc_threshold) |=> agc_error == -2'sh1;
	endproperty
	a_agc_err: assert property (p_agc_err) else $error("gain error sign wrong");

	property p_feedback;
		wr_chip ##1 1'b1 |=> car_feedback_en == $past(cfg_wdata[9], 2);
	endproperty
	a_feedback: assert property (p_feedback) else $error("feedback enable wrong");

	property p_sph_hold;
		(!chip_cfg_r.sph_continuous && !output_data_valid) |=> $stable(sample_phase_out);
	endproperty
	a_sph_hold: assert property (p_sph_hold) else $error("phase pins moved");

	property p_sph_sel0;
		(chip_cfg_r.sph_continuous && chip_cfg_r.sph_select == 2'h0)
			|=> sample_phase_out == $past(rsmp_phase_acc[28:24]);
	endproperty
	a_sph_sel0: assert property (p_sph_sel0) else $error("phase window wrong");

	property p_clear_set;
		(wr_chip && cfg_wdata[`CC_CLEAR_BIT]) |-> ##2 clear_lines == 6'h3F;
	endproperty
	a_clear_set: assert property (p_clear_set) else $error("clear not applied");

	// Stored bit decides, since the output lags the bit by one edge
	property p_clear_hold;
		(chip_cfg_r.clear_acc && !wr_chip) |=> clear_lines == 6'h3F;
	endproperty
	a_clear_hold: assert property (p_clear_hold) else $error("clear released early");

	property p_clear_release;
		!chip_cfg_r.clear_acc |=> clear_lines == 6'h00;
	endproperty
	a_clear_release: assert property (p_clear_release) else $error("clear not released");

	property p_phase;
		wr_phase |-> ##2 phase_offset_word[31:24] == $past(cfg_wdata[7:0], 2);
	endproperty
	a_phase: assert property (p_phase) else $error("phase offset wrong");

	property p_phase_low;
		phase_offset_word[`PHASE_FRAC_BITS-1:0] == 24'h000000;
	endproperty
	a_phase_low: assert property (p_phase_low) else $error("phase low bits set");

	c_clear: cover property (wr_chip && cfg_wdata[`CC_CLEAR_BIT] ##3 wr_chip && !cfg_wdata[14]);
	c_gated: cover property (!chip_cfg_r.sph_continuous && output_data_valid);
	c_neg_phase: cover property (wr_phase && cfg_wdata[7]);
endmodule

// ==== host_model.sv ====
// Purpose: Host side of the register write/read port
// Assumes: Whole 32-bit words, one write strobe per word
// Notes: Drives at the rising edge by non-blocking assignment
module host_model (
	input wire logic clk,
	output logic cfg_we,
	output logic [3:0] cfg_addr,
	output logic [31:0] cfg_wdata,
	input wire logic [31:0] cfg_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==================================================================
	// Idle bus
	initial begin
		cfg_we = 1'b0;
		cfg_addr = 4'h0;
		cfg_wdata = 32'h0;
	end
	// One strobe per word; reserved bits are the caller's choice
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		cfg_we <= 1'b1;
		cfg_addr <= a;
		cfg_wdata <= d;
		@(posedge clk);
		cfg_we <= 1'b0;
		// Stale data is inverted so a late sample cannot look right
		cfg_wdata <= ~d;
	endtask
	// Read data is registered, so it is taken one edge after the address
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		cfg_addr <= a;
		@(posedge clk);
		#1;
		d = cfg_rdata;
	endtask
endmodule

// ==== tuner_config_registers_tb_top.sv ====
// Purpose: Self-checking bench for the tuner configuration bank
// Assumes: Outputs act one edge after a write lands
// Notes: Reset values, table rows, then clear, gating, bus and mid-run reset cases
`include "tuner_cfg_regs.svh"
module tuner_config_registers_tb_top import tuner_cfg_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	// ==================================================================
	// Signals
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic cfg_we;
	logic [3:0] cfg_addr;
	logic [31:0] cfg_wdata, cfg_rdata, rd_val;
	logic [9:0] lvl = 10'h0, lth = 10'h0;
	logic [31:0] ofs = 32'h89ABCDEF, acc = 32'hA5C36E91;
	logic valid = 1'b0, stb_in = 1'b0;
	logic level_compare_out, agc_bypass, car_fb, rsmp_fb, sample_strobe;
	logic signed [1:0] agc_error;
	logic [31:0] car_out, rsmp_out, phase_offset_word;
	logic [4:0] sample_phase_out;
	clear_lines_t clear_lines;
	logic [22:0] decim_cfg;
	int error_cnt = 0;
	int cmp_count = 0;
	// Table row: chip word and inputs beside expected outputs
	typedef struct packed {
		logic [15:0] cfg;
		logic [9:0] lv, th;
		logic lco;
		logic [1:0] err;
		logic [31:0] car, rs;
		logic [4:0] sph;
	} row_t;
	row_t rows [4] = '{
		'{16'h21E5, 10'h200, 10'h1FF, 1'b1, 2'b01, 32'h89000000, 32'h89ABCDEF, 5'h05},
		'{16'h2FCA, 10'h100, 10'h100, 1'b1, 2'b01, 32'h89AB0000, 32'h89ABCD00, 5'h12},
		'{16'h32B5, 10'h100, 10'h100, 1'b0, 2'b11, 32'h89ABCD00, 32'h00000000, 5'h09},
		'{16'h7D18, 10'h3FF, 10'h000, 1'b0, 2'b11, 32'h00000000, 32'h89000000, 5'h14}};
	always #4 clk = ~clk;
	// ==================================================================
	// Design and host
	host_model hm (.clk(clk), .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
		.cfg_rdata(cfg_rdata));
	tuner_cfg_bank dut (.clk(clk), .nrst(nrst), .cfg_we(cfg_we), .cfg_addr(cfg_addr),
		.cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .level_in(lvl), .level_threshold(lth),
		.level_compare_out(level_compare_out), .agc_mag_in(lvl), .agc_threshold(lth),
		.agc_error(agc_error), .agc_bypass(agc_bypass), .car_ofs_in(ofs), .car_ofs_out(car_out),
		.rsmp_ofs_in(ofs), .rsmp_ofs_out(rsmp_out), .car_feedback_en(car_fb),
		.rsmp_feedback_en(rsmp_fb), .rsmp_phase_acc(acc), .output_data_valid(valid),
		.sample_strobe_in(stb_in), .sample_phase_out(sample_phase_out),
		.sample_strobe(sample_strobe), .clear_lines(clear_lines),
		.phase_offset_word(phase_offset_word), .decim_cfg(decim_cfg));
	// ==================================================================
	// Compare, settle and close
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic settle();
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic test_done();
		$display("comparisons=%0d mismatches=%0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Watchdog, far beyond the 70 or so cycles the run needs
	initial begin
		#40000;
		error_cnt++;
		test_done();
	end
	// ==================================================================
	// Main sequence
	initial begin
		repeat (3) @(posedge clk);
		#1;
		check(agc_error, 2'b01);
		check(clear_lines, 6'h00);
		@(posedge clk);
		nrst <= 1'b1;
		// Table rows
		foreach (rows[i]) begin
			@(posedge clk);
			lvl <= rows[i].lv;
			lth <= rows[i].th;
			hm.wr(`IDX_CHIP_CFG, {16'h0, rows[i].cfg});
			settle();
			check(level_compare_out, rows[i].lco);
			check(agc_bypass, rows[i].cfg[1]);
			check($unsigned(agc_error), rows[i].err);
			check(car_out, rows[i].car);
			check(rsmp_out, rows[i].rs);
			check({car_fb, rsmp_fb}, {rows[i].cfg[9], rows[i].cfg[10]});
			check(sample_phase_out, rows[i].sph);
			check(clear_lines, {6{rows[i].cfg[14]}});
			hm.rd(`IDX_CHIP_CFG, rd_val);
			check(rd_val, {17'h0, rows[i].cfg[14:0]});
			$display("row %0d done", i);
		end
		// Clear holds through an unmapped write, then drops on a write with only reserved bits set
		hm.wr(4'hF, 32'h0);
		settle();
		check(clear_lines, 6'h3F);
		hm.wr(`IDX_CHIP_CFG, 32'hFFFF8000);
		settle();
		check(clear_lines, 6'h00);
		check(car_out, 32'h0);
		$display("clear test done");
		// Valid-gated phase window holds until valid rises
		@(posedge clk);
		acc <= 32'h1F000000;
		stb_in <= 1'b1;
		settle();
		check(sample_phase_out, 5'h14);
		check(sample_strobe, 1'b0);
		@(posedge clk);
		valid <= 1'b1;
		settle();
		check(sample_phase_out, 5'h1F);
		check(sample_strobe, 1'b1);
		$display("gating test done");
		// Phase offset extremes, the negative one with reserved bits set; then filter word and unmapped read
		hm.wr(`IDX_PHASE_OFS, 32'hFFFFFF80);
		settle();
		check(phase_offset_word, 32'h80000000);
		hm.rd(`IDX_PHASE_OFS, rd_val);
		check(rd_val, 32'h00000080);
		hm.wr(`IDX_PHASE_OFS, 32'h0000007F);
		settle();
		check(phase_offset_word, 32'h7F000000);
		hm.wr(`IDX_DECIM_CFG, 32'hFFFFFFFF);
		hm.rd(`IDX_DECIM_CFG, rd_val);
		check(rd_val, 32'h007FFFFF);
		check(decim_cfg, 23'h7FFFFF);
		hm.rd(4'h3, rd_val);
		check(rd_val, 32'h0);
		$display("bus test done");
		// Second reset in mid-run clears the bank
		@(posedge clk);
		nrst <= 1'b0;
		@(posedge clk);
		#1;
		check(phase_offset_word, 32'h0);
		@(posedge clk);
		nrst <= 1'b1;
		hm.rd(`IDX_CHIP_CFG, rd_val);
		check(rd_val, 32'h0);
		$display("reset test done");
		test_done();
	end
endmodule
